//--- ivf_irq_ctrl.sv
// Purpose: Request flags, enables, global enable and vectoring for the core
// Assumes: mclk at 25 MHz; peripheral events are one-cycle pulses on mclk
// Notes: Register read data stand only in the cycle after the read strobe
//
// How it works
// RULE_01: No vector is taken while the global enable bit is low.
// RULE_02: Taking a vector pushes the return address and loads vector address 8.
// RULE_03: One save slot holds accumulator and flags, reset-cause bits excluded.
// RULE_04: Every selected pin edge sets the pin request flag, enabled or not.
// RULE_05: A vector needs a set flag, its enable bit, and global enable.
// RULE_06: A disabled source still sets its flag but never causes a vector.
// RULE_07: Pin edge during sleep latches its flag; vector follows wakeup at once.
// RULE_08: Edge field bits 4:3: 01 rising, 10 falling, 11 both, 00 reserved.
// RULE_09: First timer overflow sets its request flag regardless of enable.
// RULE_10: Second timer overflow sets its request flag regardless of enable.
// RULE_11: Bus transfer completion sets its request flag regardless of enable.
// RULE_12: First capture stop sets its request flag regardless of enable.
// RULE_13: Vector entry clears global enable; return from service sets it again.
// RULE_14: Software clears request flags; vectoring leaves them untouched.
// RULE_15: Enable and request share bit map 0,1,2,4,5,6; both reset to zero.
// RULE_16: Second capture stop sets its request flag regardless of enable.
// RULE_17: No hardware priority; all sources share one vector.
// RULE_18: A flag set in the same cycle as its clear stays set.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ivf_defines.svh"

module ivf_irq_ctrl
    import ivf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External pin
    input wire logic ext_pin_in,
    // Peripheral events
    input wire logic timer_a_ovf,
    input wire logic timer_b_ovf,
    input wire logic bus_link_done,
    input wire logic capture_a_stop,
    input wire logic capture_b_stop,
    // Core sequencer
    input wire logic core_boundary,
    input wire logic core_sleep,
    input wire logic core_irq_return,
    input wire logic [`IVF_PC_W-1:0] core_ret_pc,
    output logic irq_take,
    output logic [`IVF_PC_W-1:0] pc_load_addr,
    output logic ret_valid,
    output logic [`IVF_PC_W-1:0] ret_addr,
    output logic wake_req,
    // Context save
    input wire logic core_save,
    input wire logic core_restore,
    input wire logic [7:0] core_accum,
    input wire logic [7:0] core_flags,
    output logic [7:0] accum_restore,
    output logic [7:0] flags_restore,
    output logic restore_done,
    // System interrupt
    output logic irq_out
);

    logic [7:0] edge_q, edge_d;
    logic [7:0] req_q, req_d;
    logic [7:0] en_q, en_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic gie_q, gie_d;
    logic [2:0] sp_q, sp_d, sp_up;
    logic take_q, take_d;
    logic retv_q, retv_d;
    logic wake_q, wake_d;
    ivf_pc_t pcl_q, pcl_d;
    ivf_pc_t ret_q, ret_d;
    ivf_pc_t stack_mem [0:`IVF_STACK_DEPTH-1];
    logic ext_trig, ext_change;
    logic pend_any, take_c;
    logic [7:0] evt;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] src_bits(input logic [7:0] v);
        src_bits = v & `IVF_SRC_MASK;
    endfunction

    function automatic logic sel(input logic [7:0] a, input logic [7:0] b);
        sel = (a == b);
    endfunction

    // ****************************************
    // Pin edge and context buffer
    // ****************************************
    ivf_pin_edge u_pin_edge
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin_raw(ext_pin_in),
        .edge_sel(edge_q[`IVF_EDGE_HI:`IVF_EDGE_LO]),
        .trig(ext_trig),
        .change(ext_change)
    );

    ivf_save_buf u_save_buf
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .save_stb(core_save),
        .restore_stb(core_restore),
        .accum_in(core_accum),
        .flags_in(core_flags),
        .accum_out(accum_restore),
        .flags_out(flags_restore),
        .restore_done(restore_done)
    );

    // ****************************************
    // Events and vector decision
    // ****************************************
    always_comb
    begin
        evt = 8'h00;
        evt[`IVF_BIT_EXT] = ext_trig; // [RULE_04] [RULE_07]
        evt[`IVF_BIT_CAPA] = capture_a_stop; // [RULE_12]
        evt[`IVF_BIT_CAPB] = capture_b_stop; // [RULE_16]
        evt[`IVF_BIT_TMRA] = timer_a_ovf; // [RULE_09]
        evt[`IVF_BIT_TMRB] = timer_b_ovf; // [RULE_10]
        evt[`IVF_BIT_BUS] = bus_link_done; // [RULE_11]
        pend_any = |(req_q & en_q); // [RULE_05] [RULE_06] [RULE_17]
        take_c = core_boundary & ~core_sleep & gie_q & pend_any & ~core_irq_return; // [RULE_01]
        sp_up = 3'(sp_q + 3'd1);
    end

    // ****************************************
    // Register file
    // ****************************************
    always_comb
    begin
        edge_d = edge_q;
        en_d = en_q;
        mask_d = mask_q;
        req_d = req_q;
        gie_d = gie_q;
        sp_d = sp_q;
        if (reg_wr)
        begin
            if (sel(reg_addr, `IVF_ADDR_EDGE))
            begin
                edge_d = reg_wdata & `IVF_EDGE_MASK;
            end
            if (sel(reg_addr, `IVF_ADDR_EN))
            begin
                en_d = src_bits(reg_wdata); // [RULE_15]
            end
            if (sel(reg_addr, `IVF_ADDR_REQ))
            begin
                req_d = src_bits(reg_wdata); // [RULE_15]
            end
            if (sel(reg_addr, `IVF_ADDR_MASK))
            begin
                mask_d = src_bits(reg_wdata);
            end
            if (sel(reg_addr, `IVF_ADDR_STACK))
            begin
                gie_d = reg_wdata[`IVF_GIE_BIT];
                sp_d = reg_wdata[2:0];
            end
        end
        req_d = req_d | evt; // [RULE_18] [RULE_14]
        if (core_irq_return)
        begin
            gie_d = 1'b1; // [RULE_13]
            sp_d = sp_up;
        end
        if (take_c)
        begin
            gie_d = 1'b0; // [RULE_13]
            sp_d = 3'(sp_q - 3'd1); // [RULE_02]
        end
        stat_d = ((reg_rd && sel(reg_addr, `IVF_ADDR_STAT)) ? 8'h00 : stat_q) | evt;
    end

    // ****************************************
    // Read port
    // ****************************************
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `IVF_ADDR_EDGE: rdata_d = edge_q;
                `IVF_ADDR_REQ: rdata_d = req_q;
                `IVF_ADDR_EN: rdata_d = en_q;
                `IVF_ADDR_STACK: rdata_d = {gie_q, 4'h0, sp_q};
                `IVF_ADDR_STAT: rdata_d = stat_q;
                `IVF_ADDR_MASK: rdata_d = mask_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Vector and return
    // ****************************************
    always_comb
    begin
        take_d = take_c;
        pcl_d = take_c ? `IVF_VECTOR_ADDR : pcl_q; // [RULE_02]
        retv_d = core_irq_return;
        ret_d = core_irq_return ? stack_mem[sp_up] : ret_q;
        wake_d = core_sleep & ext_change; // [RULE_07]
    end

    always_ff @(posedge mclk)
    begin
        if (take_c)
        begin
            stack_mem[sp_q] <= core_ret_pc; // [RULE_02]
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            edge_q <= `IVF_RST_EDGE;
            req_q <= `IVF_RST_REG;
            en_q <= `IVF_RST_REG;
            stat_q <= `IVF_RST_REG;
            mask_q <= `IVF_RST_REG;
            rdata_q <= `IVF_RST_REG;
            gie_q <= `IVF_RST_GIE;
            sp_q <= `IVF_RST_SP;
            take_q <= 1'b0;
            retv_q <= 1'b0;
            wake_q <= 1'b0;
            pcl_q <= '0;
            ret_q <= '0;
        end
        else
        begin
            edge_q <= edge_d;
            req_q <= req_d;
            en_q <= en_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            gie_q <= gie_d;
            sp_q <= sp_d;
            take_q <= take_d;
            retv_q <= retv_d;
            wake_q <= wake_d;
            pcl_q <= pcl_d;
            ret_q <= ret_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_take = take_q;
    assign pc_load_addr = pcl_q;
    assign ret_valid = retv_q;
    assign ret_addr = ret_q;
    assign wake_req = wake_q;
    assign irq_out = |(stat_q & mask_q);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_gie_gate: // [RULE_01]
    assert property (irq_take |-> $past(gie_q))
        else $error("Vector taken while global enable was low");

    chk_vector_push: // [RULE_02]
    assert property (irq_take |-> (pc_load_addr == 13'h0008) && (sp_q == 3'($past(sp_q) - 3'd1)))
        else $error("Vector address or stack level wrong on entry");

    chk_src_gate: // [RULE_05]
    assert property (irq_take |-> $past(pend_any))
        else $error("Vector taken with no enabled pending flag");

    chk_disabled_quiet: // [RULE_06]
    assert property (!pend_any |=> !irq_take)
        else $error("Vector taken for a disabled source");

    chk_gie_clear: // [RULE_13]
    assert property (irq_take |-> !gie_q)
        else $error("Global enable still set after vector entry");

    chk_return_gie: // [RULE_13]
    assert property (core_irq_return |=> gie_q && ret_valid)
        else $error("Global enable not restored on return");

    chk_ext_set: // [RULE_04]
    assert property (ext_trig |=> req_q[0])
        else $error("Pin trigger did not set its flag");

    chk_wake_vector: // [RULE_07]
    assert property (($fell(core_sleep) && gie_q && pend_any && core_boundary && !core_irq_return)
        |=> irq_take)
        else $error("No vector right after wakeup with flag pending");

    chk_tmra_set: // [RULE_09]
    assert property (timer_a_ovf |=> req_q[4])
        else $error("First timer overflow flag not set");

    chk_tmrb_set: // [RULE_10]
    assert property (timer_b_ovf |=> req_q[5])
        else $error("Second timer overflow flag not set");

    chk_bus_set: // [RULE_11]
    assert property (bus_link_done |=> req_q[6])
        else $error("Bus completion flag not set");

    chk_capa_set: // [RULE_12]
    assert property (capture_a_stop |=> req_q[1])
        else $error("First capture flag not set");

    chk_capb_set: // [RULE_16]
    assert property (capture_b_stop |=> req_q[2])
        else $error("Second capture flag not set");

    chk_set_wins: // [RULE_18]
    assert property ((reg_wr && reg_addr == 8'hc8 && !reg_wdata[4] && timer_a_ovf) |=> req_q[4])
        else $error("Flag set lost to a same-cycle clear");

    chk_map_bits: // [RULE_15]
    assert property ((req_q & 8'h88) == 8'h00 && (en_q & 8'h88) == 8'h00)
        else $error("Unused bit set in request or enable map");

    cov_vector: cover property (irq_take);
    cov_return: cover property (irq_take ##[1:50] ret_valid);
    cov_wake: cover property (wake_req ##[1:20] irq_take);
    cov_masked_flag: cover property (req_q[0] && !en_q[0] && gie_q);

endmodule

`default_nettype wire

//--- ivf_defines.svh
// Purpose: Offsets, field positions, reset values and widths of the irq block
// Assumes: Included by every design file of the block
// Notes: Definitions only
`ifndef IVF_DEFINES_SVH
`define IVF_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define IVF_ADDR_EDGE 8'hbf
`define IVF_ADDR_REQ 8'hc8
`define IVF_ADDR_EN 8'hc9
`define IVF_ADDR_STACK 8'hdf
`define IVF_ADDR_STAT 8'he8
`define IVF_ADDR_MASK 8'he9

// ****************************************
// Fields and reset values
// ****************************************
`define IVF_BIT_EXT 0
`define IVF_BIT_CAPA 1
`define IVF_BIT_CAPB 2
`define IVF_BIT_TMRA 4
`define IVF_BIT_TMRB 5
`define IVF_BIT_BUS 6
`define IVF_SRC_MASK 8'h77
`define IVF_EDGE_MASK 8'h18
`define IVF_EDGE_LO 3
`define IVF_EDGE_HI 4
`define IVF_GIE_BIT 7
`define IVF_RST_EDGE 8'h10
`define IVF_RST_GIE 1'b0
`define IVF_RST_SP 3'h7
`define IVF_RST_REG 8'h00
`define IVF_RCAUSE_MASK 8'hc0
`define IVF_PIN_IDLE 1'b1

// ****************************************
// Core side
// ****************************************
`define IVF_PC_W 13
`define IVF_VECTOR_ADDR 13'h0008
`define IVF_STACK_DEPTH 8

`endif

//--- ivf_pkg.sv
// Purpose: Types shared by the irq block
// Assumes: ivf_defines.svh on the include path
// Notes: Edge modes use the two-bit select field codes
`include "ivf_defines.svh"

package ivf_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0]
    {
        ivf_edge_rsvd = 2'b00,
        ivf_edge_rise = 2'b01,
        ivf_edge_fall = 2'b10,
        ivf_edge_both = 2'b11
    } ivf_edge_e;

    typedef logic [`IVF_PC_W-1:0] ivf_pc_t;

endpackage

//--- ivf_pin_edge.sv
// Purpose: Synchronise the external pin and detect the selected edge
// Assumes: Pin is asynchronous to mclk and idles high
// Notes: A change counts once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none
`include "ivf_defines.svh"

module ivf_pin_edge
    import ivf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pin and mode
    input wire logic pin_raw,
    input wire logic [1:0] edge_sel,
    // Detected events
    output logic trig,
    output logic change
);

    logic [2:0] sync_q, sync_d;
    logic level_q, level_d;
    logic trig_q, trig_d;
    logic chg_q, chg_d;
    logic agree, rise, fall;
    ivf_edge_e mode;

    // ****************************************
    // Edge detect
    // ****************************************
    always_comb
    begin
        sync_d = {sync_q[1:0], pin_raw};
        mode = ivf_edge_e'(edge_sel);
        agree = (sync_q[1] == sync_q[2]);
        rise = agree & sync_q[2] & ~level_q;
        fall = agree & ~sync_q[2] & level_q;
        level_d = agree ? sync_q[2] : level_q;
        chg_d = rise | fall;
        case (mode) // [RULE_08]
            ivf_edge_rise: trig_d = rise;
            ivf_edge_fall: trig_d = fall;
            ivf_edge_both: trig_d = rise | fall;
            default: trig_d = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_q <= {3{`IVF_PIN_IDLE}};
            level_q <= `IVF_PIN_IDLE;
            trig_q <= 1'b0;
            chg_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            level_q <= level_d;
            trig_q <= trig_d;
            chg_q <= chg_d;
        end
    end

    assign trig = trig_q;
    assign change = chg_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_edge_reserved: // [RULE_08]
    assert property ((edge_sel == 2'b00) |=> !trig)
        else $error("Trigger seen with reserved edge select");

    chk_edge_rise: // [RULE_08]
    assert property ((edge_sel == 2'b01 && rise) |=> trig)
        else $error("Rising edge missed in rising mode");

    chk_edge_fall: // [RULE_08]
    assert property ((edge_sel == 2'b01 && fall) |=> !trig)
        else $error("Falling edge taken in rising mode");

endmodule

`default_nettype wire

//--- ivf_save_buf.sv
// Purpose: One-level context save buffer for accumulator and flags
// Assumes: Save and restore are one-cycle strobes from the core
// Notes: Reset-cause flag bits always come from the live flags
`timescale 1ns/10ps
`default_nettype none
`include "ivf_defines.svh"

module ivf_save_buf
    import ivf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Strobes
    input wire logic save_stb,
    input wire logic restore_stb,
    // Context in
    input wire logic [7:0] accum_in,
    input wire logic [7:0] flags_in,
    // Context out
    output logic [7:0] accum_out,
    output logic [7:0] flags_out,
    output logic restore_done
);

    logic [7:0] abuf_q, abuf_d, fbuf_q, fbuf_d;
    logic [7:0] aout_q, aout_d, fout_q, fout_d;
    logic done_q, done_d;

    // ****************************************
    // Buffer
    // ****************************************
    always_comb
    begin
        abuf_d = save_stb ? accum_in : abuf_q; // [RULE_03]
        fbuf_d = save_stb ? (flags_in & ~`IVF_RCAUSE_MASK) : fbuf_q;
        aout_d = restore_stb ? abuf_q : aout_q;
        fout_d = restore_stb ? ((fbuf_q & ~`IVF_RCAUSE_MASK) | (flags_in & `IVF_RCAUSE_MASK))
            : fout_q; // [RULE_03]
        done_d = restore_stb;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            abuf_q <= `IVF_RST_REG;
            fbuf_q <= `IVF_RST_REG;
            aout_q <= `IVF_RST_REG;
            fout_q <= `IVF_RST_REG;
            done_q <= 1'b0;
        end
        else
        begin
            abuf_q <= abuf_d;
            fbuf_q <= fbuf_d;
            aout_q <= aout_d;
            fout_q <= fout_d;
            done_q <= done_d;
        end
    end

    assign accum_out = aout_q;
    assign flags_out = fout_q;
    assign restore_done = done_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_save_restore: // [RULE_03]
    assert property ((save_stb ##1 (restore_stb && !save_stb)) |=> accum_out == $past(accum_in, 2))
        else $error("Restored accumulator differs from saved value");

    chk_rcause_kept: // [RULE_03]
    assert property (restore_stb |=> (flags_out & 8'hc0) == ($past(flags_in) & 8'hc0))
        else $error("Reset-cause bits were restored from the buffer");

endmodule

`default_nettype wire

//--- ivf_core_model.sv
// Purpose: Core sequencer model facing the irq block
// Assumes: One mclk domain; bench sets the running address
// Notes: Returns from service ret_dly+1 cycles after irq_take, never if ret_dly is 0
`timescale 1ns/10ps
`default_nettype none
`include "ivf_defines.svh"

module ivf_core_model
    import ivf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Bench control
    input wire logic slow,
    input wire logic [7:0] ret_dly,
    input wire logic [`IVF_PC_W-1:0] run_pc,
    // Block side
    input wire logic irq_take,
    output logic core_boundary,
    output logic core_irq_return,
    output logic [`IVF_PC_W-1:0] core_ret_pc,
    output int take_cnt
);
    logic [7:0] cnt_q;
    logic ph_q;

    assign core_boundary = !slow || ph_q;
    assign core_ret_pc = run_pc;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q <= 8'h00;
            ph_q <= 1'b0;
            take_cnt <= 0;
            core_irq_return <= 1'b0;
        end
        else
        begin
            ph_q <= !ph_q;
            core_irq_return <= (cnt_q == 8'h01);
            if (irq_take)
            begin
                take_cnt <= take_cnt + 1;
                cnt_q <= ret_dly;
            end
            else if (cnt_q != 8'h00)
            begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb_irq_vector_flag_controller.sv
// Purpose: Self-checking bench for the irq block
// Assumes: Core model on the sequencer side; bench drives events and registers
// Notes: Seeded random values mixed with fixed corner cases
`timescale 1ns/10ps
`default_nettype none
`include "ivf_defines.svh"

module tb_irq_vector_flag_controller
    import ivf_pkg::*;
();
    logic mclk, sys_rst, reg_wr, reg_rd, ext_pin_in, core_sleep, core_save, core_restore;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, core_accum, core_flags, acc_r, flg_r, d, e;
    logic [4:0] ev;
    logic core_boundary, core_irq_return, irq_take, ret_valid, wake_req, restore_done, irq_out;
    logic slow;
    logic [7:0] ret_dly;
    logic [`IVF_PC_W-1:0] run_pc, core_ret_pc, pc_load_addr, ret_addr;
    int take_cnt, error_cnt, num_checks, seed;
    ivf_edge_e md;

    always #20 mclk = ~mclk;

    ivf_core_model core_u (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .ret_dly(ret_dly),
        .run_pc(run_pc), .irq_take(irq_take), .core_boundary(core_boundary),
        .core_irq_return(core_irq_return), .core_ret_pc(core_ret_pc), .take_cnt(take_cnt));

    ivf_irq_ctrl dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_pin_in(ext_pin_in), .timer_a_ovf(ev[0]), .timer_b_ovf(ev[1]),
        .bus_link_done(ev[2]), .capture_a_stop(ev[3]), .capture_b_stop(ev[4]),
        .core_boundary(core_boundary), .core_sleep(core_sleep),
        .core_irq_return(core_irq_return), .core_ret_pc(core_ret_pc), .irq_take(irq_take),
        .pc_load_addr(pc_load_addr), .ret_valid(ret_valid), .ret_addr(ret_addr),
        .wake_req(wake_req), .core_save(core_save), .core_restore(core_restore),
        .core_accum(core_accum), .core_flags(core_flags), .accum_restore(acc_r),
        .flags_restore(flg_r), .restore_done(restore_done), .irq_out(irq_out));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        num_checks++;
        if (got !== ex)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, ex, reg_rdata);
        @(posedge mclk);
        #1;
        chk("rdata_idle", 8'h00, reg_rdata);
    endtask

    task automatic pulse(input int i);
        @(posedge mclk);
        ev[i] <= 1'b1;
        @(posedge mclk);
        ev[i] <= 1'b0;
    endtask

    task automatic wait_for(input string nm, input int sel);
        int k;
        k = 0;
        do
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        while (!(sel == 0 ? irq_take === 1'b1 : sel == 1 ? ret_valid === 1'b1 : wake_req === 1'b1)
            && k < 60);
        chk(nm, 16'h0001, (k < 60) ? 16'h0001 : 16'h0000);
        if (k >= 60)
            end_sim();
    endtask

    function automatic logic [7:0] ev_bit(input int i);
        logic [7:0] m [5] = '{8'h10, 8'h20, 8'h40, 8'h02, 8'h04};
        return m[i];
    endfunction

    function automatic logic pin_hit(input ivf_edge_e m, input logic lvl);
        return (m == ivf_edge_both) || (m == ivf_edge_rise && lvl) || (m == ivf_edge_fall && !lvl);
    endfunction

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #2000000;
        error_cnt++;
        end_sim();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        seed = 26353;
        mclk = 0; sys_rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        ext_pin_in = 1; ev = 0; core_sleep = 0; core_save = 0; core_restore = 0;
        core_accum = 0; core_flags = 0; slow = 0; ret_dly = 0; run_pc = 0;
        error_cnt = 0; num_checks = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 0;
        rd_chk("edge_rst", 8'hbf, 8'h10);
        rd_chk("stack_rst", 8'hdf, 8'h07);
        rd_chk("req_rst", 8'hc8, 8'h00);
        rd_chk("en_rst", 8'hc9, 8'h00);
        rd_chk("unmapped", 8'h55, 8'h00);
        e = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            pulse(i);
            e = e | ev_bit(i);
            rd_chk("req_set", 8'hc8, e);
        end
        chk("no_take_dis", 0, take_cnt);
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h77);
        pulse(0);
        pulse(1);
        repeat (5) @(posedge mclk);
        chk("no_take_gie0", 0, take_cnt);
        run_pc <= $random(seed);
        slow <= $random(seed);
        ret_dly <= 8'd40;
        wr(8'hdf, 8'h87);
        wait_for("take", 0);
        chk("vector", `IVF_VECTOR_ADDR, pc_load_addr);
        rd_chk("stack_in", 8'hdf, 8'h06);
        rd_chk("req_kept", 8'hc8, 8'h30);
        chk("one_take", 1, take_cnt);
        wr(8'hc8, 8'h00);
        wait_for("ret", 1);
        chk("ret_addr", run_pc, ret_addr);
        rd_chk("stack_out", 8'hdf, 8'h87);
        ret_dly <= 8'd0;
        wr(8'hc9, 8'h00);
        @(posedge mclk);
        reg_addr <= 8'hc8;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b1;
        ev[0] <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        ev[0] <= 1'b0;
        rd_chk("set_wins", 8'hc8, 8'h10);
        for (int m = 3; m >= 0; m--)
        begin
            md = ivf_edge_e'(m);
            wr(8'hbf, {3'h0, md, 3'h0});
            for (int j = 0; j < 2; j++)
            begin
                wr(8'hc8, 8'h00);
                @(posedge mclk);
                ext_pin_in <= ~ext_pin_in;
                repeat (8) @(posedge mclk);
                rd_chk("pin_flag", 8'hc8, {7'h0, pin_hit(md, ext_pin_in)});
            end
        end
        wr(8'hbf, 8'h10);
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h01);
        wr(8'hdf, 8'h87);
        @(posedge mclk);
        core_sleep <= 1'b1;
        ext_pin_in <= 1'b0;
        wait_for("wake", 2);
        repeat (4) @(posedge mclk);
        chk("no_take_sleep", 1, take_cnt);
        core_sleep <= 1'b0;
        wait_for("wake_take", 0);
        chk("wake_vector", `IVF_VECTOR_ADDR, pc_load_addr);
        rd_chk("stat_clr", 8'he8, 8'h77);
        wr(8'he9, 8'h10);
        pulse(0);
        #1;
        chk("irq_out_hi", 1, irq_out);
        pulse(1);
        rd_chk("stat", 8'he8, 8'h30);
        chk("irq_out_lo", 0, irq_out);
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            e = $random(seed);
            @(posedge mclk);
            core_accum <= d;
            core_flags <= e;
            core_save <= 1'b1;
            @(posedge mclk);
            core_save <= 1'b0;
            core_accum <= ~d;
            core_flags <= ~e;
            core_restore <= 1'b1;
            @(posedge mclk);
            core_restore <= 1'b0;
            #1;
            chk("rst_done", 1, restore_done);
            chk("accum", d, acc_r);
            chk("flags", {~e[7:6], e[5:0]}, flg_r);
        end
        end_sim();
    end
endmodule
`default_nettype wire
